// ---- gpc_port.sv ----
// GPIO for ports A, B and C with level-change interrupt and debug pin emulation.
// Assumes pads, periph outputs and debug unit outside; Avalon-MM master on core_clk.
`timescale 1ns/1ps
module gpc_port
  import gpc_pkg::*;
#(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  arst_n,
  // Avalon-MM slave
  input  wire logic [GPC_ADDR_W-1:0] avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [GPC_DATA_W-1:0] avs_writedata,
  output logic      [GPC_DATA_W-1:0] avs_readdata,
  output logic                       avs_waitrequest,
  // Pads
  input  wire logic [W-1:0]          pad_in_a,
  input  wire logic [W-1:0]          pad_in_b,
  input  wire logic [W-1:0]          pad_in_c,
  output logic      [W-1:0]          pad_out_a,
  output logic      [W-1:0]          pad_out_b,
  output logic      [W-1:0]          pad_out_c,
  output logic      [W-1:0]          pad_oe_a,
  output logic      [W-1:0]          pad_oe_b,
  output logic      [W-1:0]          pad_oe_c,
  output logic      [W-1:0]          pad_pullup_a,
  output logic      [W-1:0]          pad_pullup_b,
  output logic      [W-1:0]          pad_pullup_c,
  output logic      [W-1:0]          port_a_input_kill,
  // Peripheral outputs
  input  wire logic [W-1:0]          periph_out_a,
  input  wire logic [W-1:0]          periph_out_b,
  input  wire logic [W-1:0]          periph_out_c,
  // Debug unit
  input  wire logic                  debugger_attach,
  input  wire logic [1:0]            dbg_emu_level,
  output logic      [1:0]            dbg_out_value,
  output logic      [1:0]            dbg_out_select,
  // Interrupt
  output logic                       irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers

  logic [3*W:0] sync_bus;
  logic [W-1:0] sync_lvl [GPC_PORTS];
  logic         attach_s;

  gpc_sync #(
    .WIDTH (3*W+1)
  ) u_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .async_in ({debugger_attach, pad_in_c, pad_in_b, pad_in_a}),
    .sync_out (sync_bus)
  );

  assign sync_lvl[0] = sync_bus[W-1:0];
  assign sync_lvl[1] = sync_bus[2*W-1:W];
  assign sync_lvl[2] = sync_bus[3*W-1:2*W];
  assign attach_s    = sync_bus[3*W];

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic [W-1:0] dir      [GPC_PORTS];
  logic [W-1:0] alt      [GPC_PORTS];
  logic [W-1:0] outv     [GPC_PORTS];
  logic [W-1:0] ien      [GPC_PORTS];
  logic [W-1:0] stat     [GPC_PORTS];
  logic [W-1:0] prev     [GPC_PORTS];
  logic [W-1:0] kill;
  logic [W-1:0] next_dir  [GPC_PORTS];
  logic [W-1:0] next_alt  [GPC_PORTS];
  logic [W-1:0] next_outv [GPC_PORTS];
  logic [W-1:0] next_ien  [GPC_PORTS];
  logic [W-1:0] next_stat [GPC_PORTS];
  logic [W-1:0] next_prev [GPC_PORTS];
  logic [W-1:0] next_kill;
  logic [W-1:0] level    [GPC_PORTS];
  logic [W-1:0] next_pout [GPC_PORTS];
  logic [W-1:0] next_poe  [GPC_PORTS];
  logic [W-1:0] next_ppu  [GPC_PORTS];
  logic [GPC_DATA_W-1:0] next_rdata;
  logic         next_wait;
  logic         next_irq;
  logic         take;

  // Port-relative register hit, shared by read and write decode
  function automatic logic hit(input logic [7:0] adr, input int p, input logic [7:0] off);
    logic [7:0] base;
    base = 8'(p) * GPC_STRIDE;
    return adr == 8'(base + off);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // Effective levels

  always_comb begin
    for (int p = 0; p < GPC_PORTS; p++) begin
      level[p] = sync_lvl[p];
    end
    level[GPC_PORT_A] = sync_lvl[GPC_PORT_A] & ~kill;
    if (attach_s) begin
      level[GPC_PORT_B][GPC_DBG_HI:GPC_DBG_LO] = dbg_emu_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus, registers and change detection

  // Access completes on the edge where waitrequest is seen low
  assign take = (avs_read | avs_write) & ~avs_waitrequest;

  always_comb begin
    logic [W-1:0] chg;
    logic [W-1:0] clr;
    logic         any;
    chg       = '0;
    clr       = '0;
    any       = 1'b0;
    next_kill = kill;
    if (take && avs_write && avs_address == GPC_ADR_KILL) begin
      next_kill = avs_writedata[W-1:0];
    end
    for (int p = 0; p < GPC_PORTS; p++) begin
      next_dir[p]  = dir[p];
      next_alt[p]  = alt[p];
      next_outv[p] = outv[p];
      next_ien[p]  = ien[p];
      next_prev[p] = level[p];
      clr          = '0;
      if (take && avs_write) begin
        if (hit(avs_address, p, GPC_OFF_DIR)) next_dir[p] = avs_writedata[W-1:0];
        if (hit(avs_address, p, GPC_OFF_ALT)) next_alt[p] = avs_writedata[W-1:0];
        if (hit(avs_address, p, GPC_OFF_OUT)) next_outv[p] = avs_writedata[W-1:0];
        if (hit(avs_address, p, GPC_OFF_IEN)) next_ien[p] = avs_writedata[W-1:0];
        if (hit(avs_address, p, GPC_OFF_CLR)) clr = avs_writedata[W-1:0];
      end
      if (take && avs_read && hit(avs_address, p, GPC_OFF_PIN)) begin
        clr = clr | ien[p];
      end
      chg = (level[p] ^ prev[p]) & ien[p];
      if (p == GPC_PORT_A) begin
        chg = chg & ~kill & ~next_kill;
      end
      // Set beats clear so a change during the clearing read is kept
      next_stat[p] = (stat[p] & ~clr) | chg;
      any          = any | (|(next_stat[p] & next_ien[p]));
    end
    next_irq = any;
  end

  always_comb begin
    next_wait  = ~((avs_read | avs_write) & avs_waitrequest);
    next_rdata = '0;
    if (avs_read) begin
      if (avs_address == GPC_ADR_KILL) next_rdata[W-1:0] = kill;
      if (avs_address == GPC_ADR_DBG) next_rdata[0] = attach_s;
      for (int p = 0; p < GPC_PORTS; p++) begin
        if (hit(avs_address, p, GPC_OFF_DIR)) next_rdata[W-1:0] = dir[p];
        if (hit(avs_address, p, GPC_OFF_ALT)) next_rdata[W-1:0] = alt[p];
        if (hit(avs_address, p, GPC_OFF_OUT)) next_rdata[W-1:0] = outv[p];
        if (hit(avs_address, p, GPC_OFF_IEN)) next_rdata[W-1:0] = ien[p];
        if (hit(avs_address, p, GPC_OFF_PIN)) next_rdata[W-1:0] = level[p];
        if (hit(avs_address, p, GPC_OFF_STAT)) next_rdata[W-1:0] = stat[p];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad drive

  always_comb begin
    for (int p = 0; p < GPC_PORTS; p++) begin
      for (int i = 0; i < W; i++) begin
        next_poe[p][i] = dir[p][i];
        next_ppu[p][i] = ~dir[p][i] & outv[p][i];
        next_pout[p][i] = outv[p][i];
      end
    end
    next_pout[0] = (alt[0] & periph_out_a) | (~alt[0] & outv[0]);
    next_pout[1] = (alt[1] & periph_out_b) | (~alt[1] & outv[1]);
    next_pout[2] = (alt[2] & periph_out_c) | (~alt[2] & outv[2]);
    // Debug unit owns the shared pins while attached; the adapter drives them
    if (attach_s) begin
      next_poe[GPC_PORT_B][GPC_DBG_HI:GPC_DBG_LO] = 2'h0;
      next_ppu[GPC_PORT_B][GPC_DBG_HI:GPC_DBG_LO] = 2'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int p = 0; p < GPC_PORTS; p++) begin
        dir[p]  <= W'(GPC_RST_REG);
        alt[p]  <= W'(GPC_RST_REG);
        outv[p] <= W'(GPC_RST_REG);
        ien[p]  <= W'(GPC_RST_REG);
        stat[p] <= W'(GPC_RST_REG);
        prev[p] <= W'(GPC_RST_REG);
      end
      kill            <= W'(GPC_RST_REG);
      avs_readdata    <= '0;
      avs_waitrequest <= GPC_RST_WAIT;
      irq             <= 1'b0;
      pad_out_a       <= '0;
      pad_out_b       <= '0;
      pad_out_c       <= '0;
      pad_oe_a        <= '0;
      pad_oe_b        <= '0;
      pad_oe_c        <= '0;
      pad_pullup_a    <= '0;
      pad_pullup_b    <= '0;
      pad_pullup_c    <= '0;
      port_a_input_kill <= '0;
      dbg_out_value   <= 2'h0;
      dbg_out_select  <= 2'h0;
    end else begin
      for (int p = 0; p < GPC_PORTS; p++) begin
        dir[p]  <= next_dir[p];
        alt[p]  <= next_alt[p];
        outv[p] <= next_outv[p];
        ien[p]  <= next_ien[p];
        stat[p] <= next_stat[p];
        prev[p] <= next_prev[p];
      end
      kill            <= next_kill;
      avs_readdata    <= next_rdata;
      avs_waitrequest <= next_wait;
      irq             <= next_irq;
      pad_out_a       <= next_pout[0];
      pad_out_b       <= next_pout[1];
      pad_out_c       <= next_pout[2];
      pad_oe_a        <= next_poe[0];
      pad_oe_b        <= next_poe[1];
      pad_oe_c        <= next_poe[2];
      pad_pullup_a    <= next_ppu[0];
      pad_pullup_b    <= next_ppu[1];
      pad_pullup_c    <= next_ppu[2];
      port_a_input_kill <= next_kill;
      dbg_out_value   <= next_outv[GPC_PORT_B][GPC_DBG_HI:GPC_DBG_LO];
      dbg_out_select  <= next_dir[GPC_PORT_B][GPC_DBG_HI:GPC_DBG_LO];
    end
  end

endmodule : gpc_port

// ---- gpc_pkg.sv ----
// Package for the three-port GPIO block: register map, reset values, widths.
// Assumes byte addresses on an Avalon-MM slave with 32-bit data.
package gpc_pkg;

  localparam int          GPC_PORTS     = 3;
  localparam int          GPC_ADDR_W    = 8;
  localparam int          GPC_DATA_W    = 32;

  // Per-port window, port index times stride plus offset
  localparam logic [7:0]  GPC_STRIDE    = 8'h20;
  localparam logic [7:0]  GPC_OFF_DIR   = 8'h00;
  localparam logic [7:0]  GPC_OFF_ALT   = 8'h04;
  localparam logic [7:0]  GPC_OFF_OUT   = 8'h08;
  localparam logic [7:0]  GPC_OFF_IEN   = 8'h0C;
  localparam logic [7:0]  GPC_OFF_PIN   = 8'h10;
  localparam logic [7:0]  GPC_OFF_STAT  = 8'h14;
  localparam logic [7:0]  GPC_OFF_CLR   = 8'h18;

  // Global registers
  localparam logic [7:0]  GPC_ADR_KILL  = 8'h60;
  localparam logic [7:0]  GPC_ADR_DBG   = 8'h64;

  // Debug shared pins on port B, and port indices
  localparam int          GPC_DBG_LO    = 6;
  localparam int          GPC_DBG_HI    = 7;
  localparam int          GPC_PORT_A    = 0;
  localparam int          GPC_PORT_B    = 1;

  // Reset values
  localparam logic [7:0]  GPC_RST_REG   = 8'h00;
  localparam logic        GPC_RST_WAIT  = 1'b1;

endpackage : gpc_pkg

// ---- gpc_sync.sv ----
// Two-flop synchroniser for a bus of independent level inputs.
// Assumes each bit is a slow level; no bit-to-bit coherence is promised.
`timescale 1ns/1ps
module gpc_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule : gpc_sync

// ---- gpc_port_properties.sv ----
// Checker for gpc_port: bus handshake, pad control, change irq, debug pins.
// Assumes it is bound to gpc_port and uses the default register map.
`timescale 1ns/1ps
module gpc_port_properties #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic         core_clk,
  input wire logic         arst_n,
  // Bus
  input wire logic [7:0]   avs_address,
  input wire logic         avs_read,
  input wire logic         avs_write,
  input wire logic [31:0]  avs_readdata,
  input wire logic         avs_waitrequest,
  // Pads, debug, irq
  input wire logic [W-1:0] pad_in_c,
  input wire logic [W-1:0] pad_oe_a,
  input wire logic [W-1:0] pad_oe_b,
  input wire logic [W-1:0] pad_pullup_a,
  input wire logic [W-1:0] pad_pullup_b,
  input wire logic [W-1:0] port_a_input_kill,
  input wire logic         debugger_attach,
  input wire logic [1:0]   dbg_emu_level,
  input wire logic [1:0]   dbg_out_select,
  input wire logic         irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic rd_done;
  assign rd_done = avs_read && !avs_waitrequest;
  //////////////////////////////////////////////////////////////////////////////
  wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  wait_cause_a: assert property ($fell(avs_waitrequest) |-> $past(avs_read) || $past(avs_write))
    else $error("waitrequest low without a request");
  pull_in_a: assert property ((pad_pullup_a & pad_oe_a) == '0)
    else $error("pull-up on an output pin");
  readback_a: assert property (
    rd_done && avs_address == 8'h50 && $past(pad_in_c, 3) == pad_in_c
    && $past(pad_in_c, 2) == pad_in_c && $past(pad_in_c) == pad_in_c
    |-> avs_readdata[7:0] == pad_in_c) else $error("readback differs from pad");
  kill_read_a: assert property (
    rd_done && avs_address == 8'h10 && port_a_input_kill == $past(port_a_input_kill, 2)
    |-> (avs_readdata[7:0] & port_a_input_kill) == '0) else $error("killed pin reads 1");
  attach_oe_a: assert property (
    debugger_attach [*4] |-> pad_oe_b[7:6] == 2'b00 && pad_pullup_b[7:6] == 2'b00)
    else $error("debug pins still driven");
  dir_mirror_a: assert property (
    !debugger_attach [*4] ##0 $stable(dbg_out_select) && $stable(pad_oe_b)
    |-> pad_oe_b[7:6] == dbg_out_select) else $error("debug direction mirror wrong");
  irq_fall_a: assert property ($fell(irq) |-> !$past(avs_waitrequest))
    else $error("irq dropped without an access");
  emu_read_a: assert property (
    debugger_attach [*4] ##0 rd_done && avs_address == 8'h30
    && $past(dbg_emu_level, 3) == dbg_emu_level && $past(dbg_emu_level) == dbg_emu_level
    |-> avs_readdata[7:6] == dbg_emu_level) else $error("emulated level not read");
endmodule : gpc_port_properties

bind gpc_port gpc_port_properties #(.W(W)) u_props (
  .core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .pad_in_c(pad_in_c), .pad_oe_a(pad_oe_a), .pad_oe_b(pad_oe_b),
  .pad_pullup_a(pad_pullup_a), .pad_pullup_b(pad_pullup_b),
  .port_a_input_kill(port_a_input_kill), .debugger_attach(debugger_attach),
  .dbg_emu_level(dbg_emu_level), .dbg_out_select(dbg_out_select), .irq(irq));

// ---- gpc_pads.sv ----
// Board model of one port: the wire level each pad shows the block.
// Assumes the bench says which pins an outside source drives.
`timescale 1ns/1ps
module gpc_pads (
  // Clock
  input wire logic       core_clk,
  // Block side
  input wire logic [7:0] drv,
  input wire logic [7:0] oe,
  input wire logic [7:0] pull,
  // Outside sources
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  // Wire level
  output logic     [7:0] level
);
  // Undriven pins without pull-up wander, so a stale value is never mistaken for a level
  logic [7:0] wander = 8'h55;
  always @(posedge core_clk) wander <= ~wander;
  always_comb level = (oe & drv) | (~oe & ext_en & ext_val) | (~oe & ~ext_en & (pull | wander));
endmodule : gpc_pads

// ---- gpc_port_tb.sv ----
// Testbench for gpc_port: registers, pad control, change irq, debug emulation.
// Assumes gpc_pads as the board; the checker binds itself.
`timescale 1ns/1ps
module gpc_port_tb;
  import gpc_pkg::*;
  logic        core_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        debugger_attach = 1'b0;
  logic [1:0]  dbg_emu_level = 2'b00;
  logic [1:0]  dbg_out_value, dbg_out_select;
  logic        irq;
  logic [7:0]  kill, rdv, b;
  logic [7:0]  pin [3], pout [3], poe [3], ppu [3];
  logic [7:0]  pper [3] = '{8'h5A, 8'h3C, 8'h96};
  logic [7:0]  ee [3] = '{8'h0F, 8'h37, 8'hFF};
  logic [7:0]  ev [3] = '{8'h03, 8'h00, 8'h00};
  int          mismatches = 0;
  int          checked = 0;
  always #2.5 core_clk = ~core_clk;
  gpc_port #(.W(8)) uut (
    .core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pad_in_a(pin[0]), .pad_in_b(pin[1]), .pad_in_c(pin[2]),
    .pad_out_a(pout[0]), .pad_out_b(pout[1]), .pad_out_c(pout[2]), .pad_oe_a(poe[0]),
    .pad_oe_b(poe[1]), .pad_oe_c(poe[2]), .pad_pullup_a(ppu[0]), .pad_pullup_b(ppu[1]),
    .pad_pullup_c(ppu[2]), .port_a_input_kill(kill), .periph_out_a(pper[0]),
    .periph_out_b(pper[1]), .periph_out_c(pper[2]), .debugger_attach(debugger_attach),
    .dbg_emu_level(dbg_emu_level), .dbg_out_value(dbg_out_value),
    .dbg_out_select(dbg_out_select), .irq(irq));
  for (genvar i = 0; i < 3; i++) begin : g_pad
    gpc_pads u_pad (.core_clk(core_clk), .drv(pout[i]), .oe(poe[i]), .pull(ppu[i]),
      .ext_en(ee[i]), .ext_val(ev[i]), .level(pin[i]));
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // One bus access; read data lands in rdv
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h000000, d};
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rdv = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : acc
  task automatic finish_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  initial begin
    repeat (5000) @(posedge core_clk);
    mismatches++;
    finish_test();
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    chk("irq_rst", {7'h00, irq}, 8'h00);
    acc(0, 8'h7C, 8'h00);
    chk("unmapped", rdv, 8'h00);
    acc(0, GPC_OFF_DIR, 8'h00);
    chk("dir_rst", rdv, GPC_RST_REG);
    acc(1, GPC_OFF_DIR, 8'hF0);
    acc(1, GPC_OFF_OUT, 8'hA5);
    acc(1, GPC_OFF_ALT, 8'hC0);
    repeat (4) @(posedge core_clk);
    chk("oe_a", poe[0], 8'hF0);
    chk("out_a", pout[0] & 8'h30, 8'h20);
    chk("alt_a", pout[0] & 8'hC0, 8'h40);
    chk("pull_a", ppu[0], 8'h05);
    acc(0, GPC_OFF_PIN, 8'h00);
    chk("pin_a", rdv, 8'h63);
    acc(1, GPC_ADR_KILL, 8'h01);
    acc(0, GPC_OFF_PIN, 8'h00);
    chk("kill_pin", rdv, 8'h62);
    chk("kill", kill, 8'h01);
    for (int p = 0; p < 3; p++) begin
      b = 8'(p * 32);
      acc(1, b + GPC_OFF_IEN, 8'h03);
      ev[p] <= ev[p] ^ 8'h07;
      repeat (5) @(posedge core_clk);
      chk("irq_set", {7'h00, irq}, 8'h01);
      acc(0, b + GPC_OFF_STAT, 8'h00);
      chk("stat", rdv, (p == 0) ? 8'h02 : 8'h03);
      acc(0, b + GPC_OFF_PIN, 8'h00);
      acc(0, b + GPC_OFF_STAT, 8'h00);
      chk("stat_rd", rdv, 8'h00);
      chk("irq_rd", {7'h00, irq}, 8'h00);
      ev[p] <= ev[p] ^ 8'h02;
      repeat (5) @(posedge core_clk);
      acc(1, b + GPC_OFF_IEN, 8'h00);
      #1;
      chk("irq_mask", {7'h00, irq}, 8'h00);
      acc(1, b + GPC_OFF_CLR, 8'h02);
      acc(0, b + GPC_OFF_STAT, 8'h00);
      chk("stat_clr", rdv, 8'h00);
    end
    acc(1, 8'h40, 8'h0F);
    acc(1, 8'h44, 8'h03);
    acc(1, 8'h48, 8'hF5);
    acc(1, 8'h20, 8'hC0);
    acc(1, 8'h28, 8'h81);
    debugger_attach <= 1'b1;
    dbg_emu_level <= 2'b01;
    repeat (6) @(posedge core_clk);
    chk("dbg_sel", {6'h00, dbg_out_select}, 8'h03);
    chk("dbg_val", {6'h00, dbg_out_value}, 8'h02);
    chk("oe_b", poe[1] & 8'hC0, 8'h00);
    chk("out_b", pout[1], 8'h81);
    chk("pull_b", ppu[1], 8'h01);
    chk("out_c", pout[2], 8'hF6);
    chk("oe_c", poe[2], 8'h0F);
    chk("pull_c", ppu[2], 8'hF0);
    acc(0, 8'h30, 8'h00);
    chk("emu", rdv & 8'hC0, 8'h40);
    acc(0, GPC_ADR_DBG, 8'h00);
    chk("attach", rdv, 8'h01);
    finish_test();
  end
endmodule : gpc_port_tb
